// ==== include/pin_change_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the pin change block.
`ifndef PIN_CHANGE_REGS_VH
`define PIN_CHANGE_REGS_VH

`define PCI_ADDR_W 4
`define PCI_OFF_PORTA_RISE 4'h0
`define PCI_OFF_PORTA_FALL 4'h1
`define PCI_OFF_PORTA_FLAGS 4'h2
`define PCI_OFF_PORTB_RISE 4'h3
`define PCI_OFF_PORTB_FALL 4'h4
`define PCI_OFF_PORTB_FLAGS 4'h5
`define PCI_OFF_PORTC_RISE 4'h6
`define PCI_OFF_PORTC_FALL 4'h7
`define PCI_OFF_PORTC_FLAGS 4'h8
`define PCI_OFF_PORTE_RISE 4'h9
`define PCI_OFF_PORTE_FALL 4'ha
`define PCI_OFF_PORTE_FLAGS 4'hb
`define PCI_OFF_MAIN_CTRL 4'hc

`define PCI_BIT_GLOBAL_EN 7
`define PCI_BIT_PERIPH_EN 6
`define PCI_BIT_CHANGE_EN 3
`define PCI_BIT_COMMON_FLAG 0
`define PCI_PORTE_PIN 3
`define PCI_PORTE_MASK 8'h08
`define PCI_RESET_BYTE 8'h00
`define PCI_SYNC_STAGES 2

`endif

// ==== verilog/pin_edge_port.v ====
// One port of eight pins: synchroniser, edge detect, enables and sticky flags.
`timescale 1ns/1ps
`include "pin_change_regs.vh"

module pin_edge_port #(
    parameter WIDTH = 8,
    parameter [7:0] IMPL_MASK = 8'hff
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_pins,
    input wire i_rise_we,
    input wire i_fall_we,
    input wire i_flag_we,
    input wire [WIDTH-1:0] i_wdata,
    output wire [WIDTH-1:0] o_rise_enable,
    output wire [WIDTH-1:0] o_fall_enable,
    output wire [WIDTH-1:0] o_flags
);

////////////////////////////////////////////////////////////////////////////////
// Per-pin logic.
genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1) begin : pin
        if (IMPL_MASK[g]) begin : impl
            reg sync1_q;
            reg sync2_q;
            reg prev_q;
            reg rise_en_q;
            reg fall_en_q;
            reg flag_q;
            wire rise_hit;
            wire fall_hit;
            assign rise_hit = rise_en_q & sync2_q & ~prev_q;
            assign fall_hit = fall_en_q & ~sync2_q & prev_q;
            always @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    prev_q <= 1'b0;
                    rise_en_q <= 1'b0;
                    fall_en_q <= 1'b0;
                    flag_q <= 1'b0;
                end else begin
                    sync1_q <= i_pins[g];
                    sync2_q <= sync1_q;
                    prev_q <= sync2_q;
                    if (i_rise_we) begin
                        rise_en_q <= i_wdata[g];
                    end
                    if (i_fall_we) begin
                        fall_en_q <= i_wdata[g];
                    end
                    if (rise_hit | fall_hit) begin
                        flag_q <= 1'b1;
                    end else if (i_flag_we && !i_wdata[g]) begin
                        flag_q <= 1'b0;
                    end
                end
            end
            assign o_rise_enable[g] = rise_en_q;
            assign o_fall_enable[g] = fall_en_q;
            assign o_flags[g] = flag_q;
        end else begin : none
            assign o_rise_enable[g] = 1'b0;
            assign o_fall_enable[g] = 1'b0;
            assign o_flags[g] = 1'b0;
        end
    end
endgenerate

endmodule

// ==== verilog/pin_change_interrupt.v ====
// Pin change interrupt block with its register port.
// Function
// - Per port B pin rising edge enable.
// - Per port B pin falling edge enable.
// - Enabled rising edge sets pin flag.
// - Enabled falling edge sets pin flag.
// - Edge sets pin and common flag.
// - Flags set by hardware, software clears.
// - Port E only pin 3 implemented.
// - Port E pin 3 flags either edge.
// - Ports A and C behave as B.
// - Main control bits 7, 6, 3, 0.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_change_regs.vh"

module pin_change_interrupt #(
    parameter WIDTH = 8
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_porta_pin,
    input wire [WIDTH-1:0] i_portb_pin,
    input wire [WIDTH-1:0] i_portc_pin,
    input wire [WIDTH-1:0] i_porte_pin,
    input wire [`PCI_ADDR_W-1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [7:0] o_rdata,
    output wire o_common_change_flag,
    output wire o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Address decode: one select line per register index.
// An unmapped index selects nothing, so a write there is ignored.
reg sel_a_r;
reg sel_a_f;
reg sel_a_g;
reg sel_b_r;
reg sel_b_f;
reg sel_b_g;
reg sel_c_r;
reg sel_c_f;
reg sel_c_g;
reg sel_e_r;
reg sel_e_f;
reg sel_e_g;
reg sel_ctl;

always @* begin
    sel_a_r = 1'b0;
    sel_a_f = 1'b0;
    sel_a_g = 1'b0;
    sel_b_r = 1'b0;
    sel_b_f = 1'b0;
    sel_b_g = 1'b0;
    sel_c_r = 1'b0;
    sel_c_f = 1'b0;
    sel_c_g = 1'b0;
    sel_e_r = 1'b0;
    sel_e_f = 1'b0;
    sel_e_g = 1'b0;
    sel_ctl = 1'b0;

    if (i_addr == `PCI_OFF_PORTA_RISE) begin
        sel_a_r = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTA_FALL) begin
        sel_a_f = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTA_FLAGS) begin
        sel_a_g = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTB_RISE) begin
        sel_b_r = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTB_FALL) begin
        sel_b_f = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTB_FLAGS) begin
        sel_b_g = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTC_RISE) begin
        sel_c_r = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTC_FALL) begin
        sel_c_f = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTC_FLAGS) begin
        sel_c_g = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTE_RISE) begin
        sel_e_r = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTE_FALL) begin
        sel_e_f = 1'b1;
    end else if (i_addr == `PCI_OFF_PORTE_FLAGS) begin
        sel_e_g = 1'b1;
    end else if (i_addr == `PCI_OFF_MAIN_CTRL) begin
        sel_ctl = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write strobes.
// A strobe only reaches the register that the index selects.
wire wr_a_r = i_wr & sel_a_r;
wire wr_a_f = i_wr & sel_a_f;
wire wr_a_g = i_wr & sel_a_g;
wire wr_b_r = i_wr & sel_b_r;
wire wr_b_f = i_wr & sel_b_f;
wire wr_b_g = i_wr & sel_b_g;
wire wr_c_r = i_wr & sel_c_r;
wire wr_c_f = i_wr & sel_c_f;
wire wr_c_g = i_wr & sel_c_g;
wire wr_e_r = i_wr & sel_e_r;
wire wr_e_f = i_wr & sel_e_f;
wire wr_e_g = i_wr & sel_e_g;
wire wr_ctl = i_wr & sel_ctl;

////////////////////////////////////////////////////////////////////////////////
// Port instances.
wire [WIDTH-1:0] porta_rise_enable;
wire [WIDTH-1:0] porta_fall_enable;
wire [WIDTH-1:0] porta_change_flags;
wire [WIDTH-1:0] portb_rise_enable;
wire [WIDTH-1:0] portb_fall_enable;
wire [WIDTH-1:0] portb_change_flags;
wire [WIDTH-1:0] portc_rise_enable;
wire [WIDTH-1:0] portc_fall_enable;
wire [WIDTH-1:0] portc_change_flags;
wire [WIDTH-1:0] porte_rise_enable;
wire [WIDTH-1:0] porte_fall_enable;
wire [WIDTH-1:0] porte_change_flags;

// Port A: all eight pins are watched for changes.
pin_edge_port #(.WIDTH(WIDTH), .IMPL_MASK(8'hff)) u_porta (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_porta_pin),
    .i_rise_we(wr_a_r),
    .i_fall_we(wr_a_f),
    .i_flag_we(wr_a_g),
    .i_wdata(i_wdata[WIDTH-1:0]),
    .o_rise_enable(porta_rise_enable),
    .o_fall_enable(porta_fall_enable),
    .o_flags(porta_change_flags)
);

// Port B: all eight pins are watched for changes.
pin_edge_port #(.WIDTH(WIDTH), .IMPL_MASK(8'hff)) u_portb (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_portb_pin),
    .i_rise_we(wr_b_r),
    .i_fall_we(wr_b_f),
    .i_flag_we(wr_b_g),
    .i_wdata(i_wdata[WIDTH-1:0]),
    .o_rise_enable(portb_rise_enable),
    .o_fall_enable(portb_fall_enable),
    .o_flags(portb_change_flags)
);

// Port C: all eight pins are watched for changes.
pin_edge_port #(.WIDTH(WIDTH), .IMPL_MASK(8'hff)) u_portc (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_portc_pin),
    .i_rise_we(wr_c_r),
    .i_fall_we(wr_c_f),
    .i_flag_we(wr_c_g),
    .i_wdata(i_wdata[WIDTH-1:0]),
    .o_rise_enable(portc_rise_enable),
    .o_fall_enable(portc_fall_enable),
    .o_flags(portc_change_flags)
);

// Port E: only pin 3 is watched; the other bits read as zero.
pin_edge_port #(.WIDTH(WIDTH), .IMPL_MASK(`PCI_PORTE_MASK)) u_porte (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_porte_pin),
    .i_rise_we(wr_e_r),
    .i_fall_we(wr_e_f),
    .i_flag_we(wr_e_g),
    .i_wdata(i_wdata[WIDTH-1:0]),
    .o_rise_enable(porte_rise_enable),
    .o_fall_enable(porte_fall_enable),
    .o_flags(porte_change_flags)
);

////////////////////////////////////////////////////////////////////////////////
// Common change flag.
wire porta_any;
wire portb_any;
wire portc_any;
wire porte_any;
wire common_change_flag;

// The common flag stays high until software has cleared every pin flag.
assign porta_any = |porta_change_flags;
assign portb_any = |portb_change_flags;
assign portc_any = |portc_change_flags;
assign porte_any = |porte_change_flags;
assign common_change_flag = porta_any | portb_any | portc_any | porte_any;

assign o_common_change_flag = common_change_flag;

////////////////////////////////////////////////////////////////////////////////
// Main interrupt control.
reg global_irq_enable_q;
reg peripheral_irq_enable_q;
reg change_irq_enable_q;
reg global_irq_enable_d;
reg peripheral_irq_enable_d;
reg change_irq_enable_d;
reg [7:0] rdata_q;
wire [7:0] main_interrupt_control;

// Bit 0 is read-only, so a write to this register leaves the common flag alone.
always @* begin
    global_irq_enable_d = global_irq_enable_q;
    peripheral_irq_enable_d = peripheral_irq_enable_q;
    change_irq_enable_d = change_irq_enable_q;
    if (wr_ctl) begin
        global_irq_enable_d = i_wdata[`PCI_BIT_GLOBAL_EN];
        peripheral_irq_enable_d = i_wdata[`PCI_BIT_PERIPH_EN];
        change_irq_enable_d = i_wdata[`PCI_BIT_CHANGE_EN];
    end
end

always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
        global_irq_enable_q <= 1'b0;
        peripheral_irq_enable_q <= 1'b0;
        change_irq_enable_q <= 1'b0;
    end else begin
        global_irq_enable_q <= global_irq_enable_d;
        peripheral_irq_enable_q <= peripheral_irq_enable_d;
        change_irq_enable_q <= change_irq_enable_d;
    end
end

// Unused bits read as zero; the peripheral enable is only stored and read back.
assign main_interrupt_control[`PCI_BIT_GLOBAL_EN] = global_irq_enable_q;
assign main_interrupt_control[`PCI_BIT_PERIPH_EN] = peripheral_irq_enable_q;
assign main_interrupt_control[5] = 1'b0;
assign main_interrupt_control[4] = 1'b0;
assign main_interrupt_control[`PCI_BIT_CHANGE_EN] = change_irq_enable_q;
assign main_interrupt_control[2] = 1'b0;
assign main_interrupt_control[1] = 1'b0;
assign main_interrupt_control[`PCI_BIT_COMMON_FLAG] = common_change_flag;

////////////////////////////////////////////////////////////////////////////////
// Interrupt output.
wire irq_allowed;
assign irq_allowed = global_irq_enable_q & change_irq_enable_q;
assign o_irq = irq_allowed & common_change_flag;

////////////////////////////////////////////////////////////////////////////////
// Read port.
// Reads of an unmapped index return zero.
reg [7:0] rdata_d;
always @* begin
    rdata_d = `PCI_RESET_BYTE;
    if (i_addr == `PCI_OFF_PORTA_RISE) begin
        rdata_d = porta_rise_enable;
    end else if (i_addr == `PCI_OFF_PORTA_FALL) begin
        rdata_d = porta_fall_enable;
    end else if (i_addr == `PCI_OFF_PORTA_FLAGS) begin
        rdata_d = porta_change_flags;
    end else if (i_addr == `PCI_OFF_PORTB_RISE) begin
        rdata_d = portb_rise_enable;
    end else if (i_addr == `PCI_OFF_PORTB_FALL) begin
        rdata_d = portb_fall_enable;
    end else if (i_addr == `PCI_OFF_PORTB_FLAGS) begin
        rdata_d = portb_change_flags;
    end else if (i_addr == `PCI_OFF_PORTC_RISE) begin
        rdata_d = portc_rise_enable;
    end else if (i_addr == `PCI_OFF_PORTC_FALL) begin
        rdata_d = portc_fall_enable;
    end else if (i_addr == `PCI_OFF_PORTC_FLAGS) begin
        rdata_d = portc_change_flags;
    end else if (i_addr == `PCI_OFF_PORTE_RISE) begin
        rdata_d = porte_rise_enable;
    end else if (i_addr == `PCI_OFF_PORTE_FALL) begin
        rdata_d = porte_fall_enable;
    end else if (i_addr == `PCI_OFF_PORTE_FLAGS) begin
        rdata_d = porte_change_flags;
    end else if (i_addr == `PCI_OFF_MAIN_CTRL) begin
        rdata_d = main_interrupt_control;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data register.
// The data stand for one cycle after the read strobe and are zero otherwise.
always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
        rdata_q <= `PCI_RESET_BYTE;
    end else if (i_rd) begin
        rdata_q <= rdata_d;
    end else begin
        rdata_q <= `PCI_RESET_BYTE;
    end
end

assign o_rdata = rdata_q;

endmodule

// ==== tb/pin_source.sv ====
// Outside circuit that drives the four port pin buses.
`timescale 1ns/1ps
module pin_source (
    input wire i_sys_clk,
    input wire i_load,
    input wire [1:0] i_port,
    input wire [7:0] i_val,
    output reg [31:0] o_pins
);
    initial o_pins = 32'h0;
    always @(posedge i_sys_clk) begin
        if (i_load) begin
            o_pins[i_port*8 +: 8] <= i_val;
        end
    end
endmodule

// ==== tb/pin_change_asserts.sv ====
// Port checker for the pin change block.
`timescale 1ns/1ps
`include "pin_change_regs.vh"
module pin_change_asserts (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire [7:0] i_porta_pin,
    input wire [7:0] i_portb_pin,
    input wire [7:0] i_portc_pin,
    input wire [7:0] i_porte_pin,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire o_common_change_flag,
    input wire o_irq
);
    wire [24:0] pin_all = {i_porta_pin, i_portb_pin, i_portc_pin, i_porte_pin[3]};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    chk_rdata_idle:
        assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
    chk_irq_gate:
        assert property (o_irq |-> o_common_change_flag) else $error("irq without flag");
    chk_flag_cause:
        assert property ($rose(o_common_change_flag) |-> $past(pin_all, 3) != $past(pin_all, 4))
        else $error("flag without pin change");
    chk_flag_sticky:
        assert property ($fell(o_common_change_flag) |-> $past(i_wr)) else $error("flag lost");
    chk_irq_hold:
        assert property ($fell(o_irq) |-> $past(i_wr)) else $error("irq lost");
    chk_main_read:
        assert property ($past(i_rd) && $past(i_addr) == `PCI_OFF_MAIN_CTRL |->
            o_rdata[0] == $past(o_common_change_flag) && o_rdata[5:4] == 2'b00)
        else $error("main control read wrong");
    chk_porte_bits:
        assert property ($past(i_rd) && $past(i_addr) inside {4'h9, 4'ha, 4'hb} |->
            (o_rdata & 8'hf7) == 8'h00) else $error("port E spare bit set");
    chk_unmapped_zero:
        assert property ($past(i_rd) && $past(i_addr) > 4'hc |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind pin_change_interrupt pin_change_asserts i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_porta_pin(i_porta_pin), .i_portb_pin(i_portb_pin), .i_portc_pin(i_portc_pin),
    .i_porte_pin(i_porte_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_common_change_flag(o_common_change_flag), .o_irq(o_irq));

// ==== tb/tb_top.sv ====
// Self-checking bench for the pin change block.
`timescale 1ns/1ps
module tb_top;
    reg i_sys_clk, i_rst_n, i_wr, i_rd, ld;
    reg [3:0] i_addr;
    reg [7:0] i_wdata, val, ctl;
    reg [1:0] prt;
    reg [15:0] lf;
    reg [7:0] rise [0:3], fall [0:3], flg [0:3], lvl [0:3], msk [0:3];
    wire [31:0] pins;
    wire [7:0] o_rdata;
    wire o_common_change_flag, o_irq;
    integer bad_count, comparisons, p, k;
    pin_source i_pin_source (.i_sys_clk(i_sys_clk), .i_load(ld), .i_port(prt), .i_val(val),
        .o_pins(pins));
    pin_change_interrupt i_pin_change_interrupt (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_porta_pin(pins[7:0]), .i_portb_pin(pins[15:8]), .i_portc_pin(pins[23:16]),
        .i_porte_pin(pins[31:24]), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_common_change_flag(o_common_change_flag),
        .o_irq(o_irq));
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    function [7:0] anyf();
        anyf = flg[0] | flg[1] | flg[2] | flg[3];
    endfunction
    function [15:0] lfsr_next(input [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function [7:0] model(input [3:0] a);
        model = 8'h00;
        if (a == 4'hc) model = ctl | {7'h0, anyf() != 8'h00};
        else if (a < 4'hc) model = (a % 3 == 0) ? rise[a/3] : (a % 3 == 1) ? fall[a/3] : flg[a/3];
    endfunction
    task check(input [8*6-1:0] what, input [7:0] got, input [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task mwr(input [3:0] a, input [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        if (a == 4'hc) ctl = d & 8'hc8;
        else if (a < 4'hc && a % 3 == 0) rise[a/3] = d & msk[a/3];
        else if (a < 4'hc && a % 3 == 1) fall[a/3] = d & msk[a/3];
        else if (a < 4'hc) flg[a/3] = flg[a/3] & d;
    endtask
    task rd_all;
        for (k = 0; k < 16; k = k + 1) begin
            @(posedge i_sys_clk);
            i_rd <= 1'b1;
            i_addr <= k[3:0];
            @(posedge i_sys_clk);
            i_rd <= 1'b0;
            #1 check("rdata", o_rdata, model(k[3:0]));
        end
        check("irq", {6'h0, o_irq, o_common_change_flag},
            {6'h0, ctl[7] & ctl[3] & (anyf() != 8'h00), anyf() != 8'h00});
    endtask
    initial begin
        repeat (50000) @(posedge i_sys_clk);
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        {i_rst_n, i_wr, i_rd, ld, i_addr, i_wdata, prt, val, ctl} = 0;
        bad_count = 0;
        comparisons = 0;
        lf = 16'hd696;
        for (p = 0; p < 4; p = p + 1) begin
            {rise[p], fall[p], flg[p], lvl[p]} = 32'h0;
            msk[p] = (p == 3) ? 8'h08 : 8'hff;
        end
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd_all;
        $display("test reset values done");
        for (p = 0; p < 16; p = p + 1) begin
            lf = lfsr_next(lf);
            mwr(p[3:0], lf[7:0] | 8'h08);
        end
        rd_all;
        $display("test register access done");
        repeat (80) begin
            lf = lfsr_next(lf);
            p = lf[9:8];
            @(posedge i_sys_clk);
            ld <= 1'b1;
            prt <= lf[9:8];
            val <= lf[7:0];
            @(posedge i_sys_clk);
            ld <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
            flg[p] = flg[p] | (val & ~lvl[p] & rise[p]) | (~val & lvl[p] & fall[p]);
            lvl[p] = val;
            rd_all;
            mwr(lf[15:12], lf[7:0] ^ lf[15:8]);
        end
        rd_all;
        $display("test pin changes done");
        close_out;
    end
endmodule
